// File: src/frt_consts.svh
// Purpose: Register offsets, field positions, reset values and divider taps of the capture/compare timer.
// Assumes: Byte-wide CPU register port with a 4-bit address.
// Notes: Included by frt_timer and its bench by its bare name.
`ifndef FRT_CONSTS_SVH
`define FRT_CONSTS_SVH

`define FRT_OFS_IRQ_EN 4'h0
`define FRT_OFS_FLAGS 4'h1
`define FRT_OFS_CNT_HI 4'h2
`define FRT_OFS_CNT_LO 4'h3
`define FRT_OFS_CMP_HI 4'h4
`define FRT_OFS_CMP_LO 4'h5
`define FRT_OFS_CTRL 4'h6
`define FRT_OFS_OUT_CTRL 4'h7
`define FRT_OFS_CAP_A_HI 4'h8
`define FRT_OFS_CAP_A_LO 4'h9
`define FRT_OFS_CAP_B_HI 4'hA
`define FRT_OFS_CAP_B_LO 4'hB
`define FRT_OFS_CAP_C_HI 4'hC
`define FRT_OFS_CAP_C_LO 4'hD
`define FRT_OFS_CAP_D_HI 4'hE
`define FRT_OFS_CAP_D_LO 4'hF

// Flag and irq-enable byte: capture A..D at 7..4, match A/B at 3..2, wrap at 1.
`define FRT_FLAG_HI 7
`define FRT_FLAG_LO 1
`define FRT_BIT_CLR_A 0

// Control byte: edge selects A..D at 7..4.
`define FRT_BIT_EDGE_A 7
`define FRT_BIT_BUF_A 3
`define FRT_BIT_BUF_B 2
`define FRT_BIT_CKS_HI 1
`define FRT_BIT_CKS_LO 0

// Compare output control byte.
`define FRT_BIT_CMP_SEL 4
`define FRT_BIT_OE_A 3
`define FRT_BIT_OE_B 2
`define FRT_BIT_LVL_A 1
`define FRT_BIT_LVL_B 0

`define FRT_RST_IRQ_EN 8'h00
`define FRT_RST_FLAGS 8'h00
`define FRT_RST_CTRL 8'h00
`define FRT_RST_OUT_CTRL 8'hE0
`define FRT_OUT_CTRL_FIXED 8'hE0
`define FRT_RST_CMP 16'hFFFF
`define FRT_RST_WORD 16'h0000
`define FRT_CNT_MAX 16'hFFFF

// Prescaler taps: bit n of the prescaler toggles at clock/2^(n+1).
`define FRT_PRE_W 5
`define FRT_TAP_DIV2 0
`define FRT_TAP_DIV8 2
`define FRT_TAP_DIV32 4

`endif

// File: src/frt_pkg.sv
// Purpose: Types shared by the capture/compare timer modules.
// Assumes: Nothing beyond the constants header.
// Notes: Clock-source encoding matches the two clock select bits.
package frt_pkg;
  typedef logic [3:0] frt_addr_t;
  typedef logic [15:0] frt_word_t;
  typedef enum logic [1:0] {
    FRT_SRC_DIV2 = 2'b00,
    FRT_SRC_DIV8 = 2'b01,
    FRT_SRC_DIV32 = 2'b10,
    FRT_SRC_EXT = 2'b11
  } frt_src_e;
endpackage

// File: src/frt_pin_edge.sv
// Purpose: Synchronise one timer pin and detect the selected edge.
// Assumes: Pin is asynchronous to clk_i.
// Notes: Edge pulse lasts one cycle; level output is the synchronised pin.
`timescale 1ns/100ps
module frt_pin_edge
  import frt_pkg::*;
(
  input wire logic clk_i, // System clock.
  input wire logic rst_b_i, // Asynchronous reset, active low.
  input wire logic pin_i, // Asynchronous pin.
  input wire logic rise_sel_i, // 1 selects rising edge, 0 falling.
  output logic lvl_o, // Synchronised pin level.
  output logic edge_o // One-cycle pulse on the selected edge.
);
  logic meta_r;
  logic sync_r;
  logic prev_r;
  logic [2:0] warm_r;
  wire rise_w = sync_r & ~prev_r;
  wire fall_w = ~sync_r & prev_r;

  // The first flop feeds only the second, so no logic sees a metastable value.
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
      prev_r <= 1'b0;
      warm_r <= 3'h0;
    end else begin
      meta_r <= pin_i;
      sync_r <= meta_r;
      prev_r <= sync_r;
      warm_r <= {warm_r[1:0], 1'b1};
    end
  end

  // Edges are ignored until the pipeline has filled, so a pin that idles high
  // does not look like a rising edge just after reset.
  assign lvl_o = sync_r;
  assign edge_o = warm_r[2] & (rise_sel_i ? rise_w : fall_w);
endmodule

// File: src/frt_timer.sv
// Purpose: 16-bit free-running counter with two compare outputs and four capture inputs.
// Assumes: One-cycle CPU byte read/write strobes; the strobe cycle is the final state of the access.
// Notes: Read data appears one cycle after the read strobe.
`timescale 1ns/100ps
`include "frt_consts.svh"

module frt_timer
  import frt_pkg::*;
(
  input wire logic clk_i, // System clock, 125 MHz.
  input wire logic rst_b_i, // Asynchronous reset, active low.
  input wire frt_addr_t cpu_addr_i, // Register byte address.
  input wire logic cpu_wr_i, // Byte write strobe, one cycle.
  input wire logic cpu_rd_i, // Byte read strobe, one cycle.
  input wire logic [7:0] cpu_wdata_i, // Write data.
  output logic [7:0] cpu_rdata_o, // Read data, registered.
  input wire logic [3:0] capture_pin_i, // Capture pins D..A at bits 3..0.
  input wire logic ext_count_clock_pin_i, // External counter clock pin.
  output logic compare_pin_a_o, // Compare pin A level.
  output logic compare_pin_a_oe_o, // Compare pin A output enable.
  output logic compare_pin_b_o, // Compare pin B level.
  output logic compare_pin_b_oe_o, // Compare pin B output enable.
  output logic [6:0] irq_o, // Requests: 6 cap A .. 3 cap D, 2 match A, 1 match B, 0 wrap.
  output logic irq_any_o, // Any request active.
  output logic [2:0] irq_top_o // Highest-priority request, 0 = capture A.
);
  logic [7:0] irq_en_r;
  logic [7:0] flags_r;
  logic [6:0] seen_r;
  logic [7:0] ctrl_r;
  logic [7:0] out_ctrl_r;
  frt_word_t cnt_r;
  frt_word_t cmp_a_r;
  frt_word_t cmp_b_r;
  frt_word_t cap_r [4];
  logic [7:0] temp_r;
  logic [7:0] rdata_r;
  logic [`FRT_PRE_W-1:0] pre_r;
  logic src_lvl_r;
  logic pin_a_r;
  logic pin_b_r;
  logic [3:0] pend_r;
  logic [2:0] top_r;

  // Address decode.
  wire wr_w = cpu_wr_i;
  wire rd_w = cpu_rd_i;
  wire a_irq_w = cpu_addr_i == `FRT_OFS_IRQ_EN;
  wire a_flg_w = cpu_addr_i == `FRT_OFS_FLAGS;
  wire a_cnt_hi_w = cpu_addr_i == `FRT_OFS_CNT_HI;
  wire a_cnt_lo_w = cpu_addr_i == `FRT_OFS_CNT_LO;
  wire a_cmp_hi_w = cpu_addr_i == `FRT_OFS_CMP_HI;
  wire a_cmp_lo_w = cpu_addr_i == `FRT_OFS_CMP_LO;
  wire a_ctl_w = cpu_addr_i == `FRT_OFS_CTRL;
  wire a_oc_w = cpu_addr_i == `FRT_OFS_OUT_CTRL;
  wire a_cap_w = cpu_addr_i[3];
  wire [1:0] cap_idx_w = cpu_addr_i[2:1];
  wire hi_w = ~cpu_addr_i[0];
  wire cmp_sel_w = out_ctrl_r[`FRT_BIT_CMP_SEL];
  wire wr_cnt_lo_w = wr_w & a_cnt_lo_w;
  wire wr_cmp_lo_a_w = wr_w & a_cmp_lo_w & ~cmp_sel_w;
  wire wr_cmp_lo_b_w = wr_w & a_cmp_lo_w & cmp_sel_w;
  wire wr_hi_w = wr_w & hi_w & (a_cnt_hi_w | a_cmp_hi_w | a_cap_w);
  wire rd_hi_latch_w = rd_w & (a_cnt_hi_w | (a_cap_w & hi_w));
  wire [3:0] rd_cap_hi_w = (rd_w & a_cap_w & hi_w) ? (4'h1 << cap_idx_w) : 4'h0;
  wire [7:0] wdata_w = cpu_wdata_i;
  wire [15:0] wword_w = {temp_r, wdata_w};

  // Counter clock source; the external pin is inverted so that one falling-edge
  // detector serves all sources and a select change is seen as a level change.
  wire [3:0] edge_w;
  wire [3:0] cap_lvl_w;
  wire ext_lvl_w;
  frt_src_e src_w;
  assign src_w = frt_src_e'(ctrl_r[`FRT_BIT_CKS_HI:`FRT_BIT_CKS_LO]);
  logic src_now_w;
  always_comb begin
    unique case (src_w)
      FRT_SRC_DIV2: src_now_w = pre_r[`FRT_TAP_DIV2];
      FRT_SRC_DIV8: src_now_w = pre_r[`FRT_TAP_DIV8];
      FRT_SRC_DIV32: src_now_w = pre_r[`FRT_TAP_DIV32];
      FRT_SRC_EXT: src_now_w = ~ext_lvl_w;
    endcase
  end
  wire tick_w = src_lvl_r & ~src_now_w;

  // Compare match is flagged in the last state of equality, suppressed by a low-byte write.
  wire match_a_w = tick_w & (cnt_r == cmp_a_r) & ~wr_cmp_lo_a_w;
  wire match_b_w = tick_w & (cnt_r == cmp_b_r) & ~wr_cmp_lo_b_w;
  wire clr_w = match_a_w & flags_r[`FRT_BIT_CLR_A];
  wire wrap_w = tick_w & (cnt_r == `FRT_CNT_MAX) & ~wr_cnt_lo_w & ~clr_w;

  // Capture strobes, held off one state while the matching high byte is being read.
  wire buf_a_w = ctrl_r[`FRT_BIT_BUF_A];
  wire buf_b_w = ctrl_r[`FRT_BIT_BUF_B];
  wire [3:0] blk_w = {rd_cap_hi_w[3] | (buf_b_w & rd_cap_hi_w[1]),
                      rd_cap_hi_w[2] | (buf_a_w & rd_cap_hi_w[0]),
                      rd_cap_hi_w[1] | (buf_b_w & rd_cap_hi_w[3]),
                      rd_cap_hi_w[0] | (buf_a_w & rd_cap_hi_w[2])};
  wire [3:0] stb_w = (edge_w & ~blk_w) | pend_r;
  wire [3:0] pend_nxt = edge_w & blk_w;

  for (genvar g = 0; g < 4; g++) begin : g_cap_pin
    frt_pin_edge u_edge (
      .clk_i(clk_i),
      .rst_b_i(rst_b_i),
      .pin_i(capture_pin_i[g]),
      .rise_sel_i(ctrl_r[`FRT_BIT_EDGE_A - g]),
      .lvl_o(cap_lvl_w[g]),
      .edge_o(edge_w[g])
    );
  end
  frt_pin_edge u_ext (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .pin_i(ext_count_clock_pin_i),
    .rise_sel_i(1'b1),
    .lvl_o(ext_lvl_w),
    .edge_o()
  );

  // Flags: set always wins over a clear in the same cycle.
  wire [6:0] set_w = {stb_w[0], stb_w[1], stb_w[2], stb_w[3], match_a_w, match_b_w, wrap_w};
  wire [6:0] flag_w = flags_r[`FRT_FLAG_HI:`FRT_FLAG_LO];
  wire wr_flg_w = wr_w & a_flg_w;
  wire [6:0] clr_flag_w = wr_flg_w ? (seen_r & ~wdata_w[`FRT_FLAG_HI:`FRT_FLAG_LO]) : 7'h00;
  wire [6:0] flag_nxt = (flag_w & ~clr_flag_w) | set_w;
  wire [6:0] seen_nxt = (rd_w & a_flg_w) ? (seen_r | flag_w) : (wr_flg_w ? 7'h00 : seen_r);
  wire clr_a_nxt = wr_flg_w ? wdata_w[`FRT_BIT_CLR_A] : flags_r[`FRT_BIT_CLR_A];

  // Counter: clear beats a low-byte write, which beats the increment.
  wire [15:0] cnt_nxt = clr_w ? `FRT_RST_WORD :
                        wr_cnt_lo_w ? wword_w :
                        tick_w ? cnt_r + 16'h0001 : cnt_r;

  // Read mux; compare reads bypass the byte latch.
  wire frt_word_t cmp_sel_val_w = cmp_sel_w ? cmp_b_r : cmp_a_r;
  wire frt_word_t cap_sel_w = cap_r[cap_idx_w];
  wire [7:0] rmux_w = a_irq_w ? irq_en_r :
                      a_flg_w ? flags_r :
                      a_cnt_hi_w ? cnt_r[15:8] :
                      a_cmp_hi_w ? cmp_sel_val_w[15:8] :
                      a_cmp_lo_w ? cmp_sel_val_w[7:0] :
                      a_ctl_w ? ctrl_r :
                      a_oc_w ? out_ctrl_r :
                      (a_cap_w & hi_w) ? cap_sel_w[15:8] : temp_r;
  wire [7:0] temp_nxt = wr_hi_w ? wdata_w :
                        !rd_hi_latch_w ? temp_r :
                        a_cnt_hi_w ? cnt_r[7:0] : cap_sel_w[7:0];

  // Interrupt lines and priority (capture A highest, wrap lowest).
  wire [6:0] irq_w = flag_w & irq_en_r[`FRT_FLAG_HI:`FRT_FLAG_LO];
  logic [2:0] top_nxt;
  always_comb begin
    top_nxt = 3'h7;
    for (int i = 0; i < 7; i++) begin
      if (irq_w[i]) begin
        top_nxt = 3'(6 - i);
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      irq_en_r <= `FRT_RST_IRQ_EN;
      flags_r <= `FRT_RST_FLAGS;
      seen_r <= 7'h00;
      ctrl_r <= `FRT_RST_CTRL;
      out_ctrl_r <= `FRT_RST_OUT_CTRL;
      cnt_r <= `FRT_RST_WORD;
      temp_r <= 8'h00;
      rdata_r <= 8'h00;
      pre_r <= '0;
      src_lvl_r <= 1'b0;
      pend_r <= 4'h0;
      top_r <= 3'h7;
    end else begin
      flags_r <= {flag_nxt, clr_a_nxt};
      seen_r <= seen_nxt;
      cnt_r <= cnt_nxt;
      temp_r <= temp_nxt;
      pre_r <= pre_r + 1'b1;
      src_lvl_r <= src_now_w;
      pend_r <= pend_nxt;
      top_r <= top_nxt;
      if (rd_w) begin
        rdata_r <= rmux_w;
      end
      if (wr_w && a_irq_w) begin
        irq_en_r <= {wdata_w[`FRT_FLAG_HI:`FRT_FLAG_LO], 1'b0};
      end
      if (wr_w && a_ctl_w) begin
        ctrl_r <= wdata_w;
      end
      if (wr_w && a_oc_w) begin
        out_ctrl_r <= wdata_w | `FRT_OUT_CTRL_FIXED;
      end
    end
  end

  // Compare registers, captures and pin levels.
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cmp_a_r <= `FRT_RST_CMP;
      cmp_b_r <= `FRT_RST_CMP;
      cap_r <= '{default: `FRT_RST_WORD};
      pin_a_r <= 1'b0;
      pin_b_r <= 1'b0;
    end else begin
      if (wr_cmp_lo_a_w) begin
        cmp_a_r <= wword_w;
      end
      if (wr_cmp_lo_b_w) begin
        cmp_b_r <= wword_w;
      end
      if (match_a_w) begin
        pin_a_r <= out_ctrl_r[`FRT_BIT_LVL_A];
      end
      if (match_b_w) begin
        pin_b_r <= out_ctrl_r[`FRT_BIT_LVL_B];
      end
      if (stb_w[0]) begin
        cap_r[0] <= cnt_r;
      end
      if (stb_w[1]) begin
        cap_r[1] <= cnt_r;
      end
      // In buffer mode the buffer takes the old capture and ignores its own pin.
      if (buf_a_w ? stb_w[0] : stb_w[2]) begin
        cap_r[2] <= buf_a_w ? cap_r[0] : cnt_r;
      end
      if (buf_b_w ? stb_w[1] : stb_w[3]) begin
        cap_r[3] <= buf_b_w ? cap_r[1] : cnt_r;
      end
    end
  end

  assign cpu_rdata_o = rdata_r;
  assign compare_pin_a_o = pin_a_r & out_ctrl_r[`FRT_BIT_OE_A];
  assign compare_pin_a_oe_o = out_ctrl_r[`FRT_BIT_OE_A];
  assign compare_pin_b_o = pin_b_r & out_ctrl_r[`FRT_BIT_OE_B];
  assign compare_pin_b_oe_o = out_ctrl_r[`FRT_BIT_OE_B];
  assign irq_o = irq_w;
  assign irq_any_o = |irq_w;
  assign irq_top_o = top_r;

  // Checks.
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);

  match_level_a: assert property (match_a_w |=> pin_a_r == $past(out_ctrl_r[`FRT_BIT_LVL_A]))
    else $error("pin A did not take its match level");
  word_load_a: assert property (wr_cnt_lo_w && !clr_w |=> cnt_r == {$past(temp_r), $past(cpu_wdata_i)})
    else $error("counter low write did not load the word");
  read_latch_a: assert property (rd_w && a_cnt_hi_w |=> temp_r == $past(cnt_r[7:0]) && rdata_r == $past(cnt_r[15:8]))
    else $error("counter high read did not latch the low byte");
  cmp_direct_a: assert property (rd_w && a_cmp_lo_w && !cmp_sel_w |=> rdata_r == $past(cmp_a_r[7:0]))
    else $error("compare low read not taken directly");
  clear_match_a: assert property (match_a_w && flags_r[`FRT_BIT_CLR_A] |=> cnt_r == 16'h0000)
    else $error("counter not cleared on match A");
  cap_delay_a: assert property (edge_w[0] && blk_w[0] |-> !stb_w[0] ##1 stb_w[0])
    else $error("capture A not delayed by one state");
  wrap_set_a: assert property (wrap_w |=> flags_r[1])
    else $error("wrap flag not set");
  match_block_a: assert property (wr_cmp_lo_a_w && tick_w && cnt_r == cmp_a_r && !flags_r[3] |=> !flags_r[3])
    else $error("match not suppressed by compare write");
  flag_keep_a: assert property (flags_r[3] && !seen_r[2] && !match_a_w |=> flags_r[3])
    else $error("match flag A cleared without prior read");
  cap_flag_a: assert property (stb_w[2] ##1 1'b1 |-> flags_r[5])
    else $error("capture C flag not set");

  wrap_seen_c: cover property (wrap_w ##1 irq_any_o);
  buffered_c: cover property (buf_a_w && stb_w[0] ##[1:200] stb_w[0]);
  clear_c: cover property (clr_w ##[1:40] match_b_w);
endmodule

// File: tb/frt_cpu_model.sv
// Purpose: Byte-wide CPU master for the timer register port.
// Assumes: Strobes last one cycle; read data is valid one cycle after the strobe.
// Notes: Idle data lines show the inverse of the last value, so stale data is never mistaken for good.
`timescale 1ns/100ps
module frt_cpu_model
  import frt_pkg::*;
(
  input wire logic clk_i, // System clock.
  output frt_addr_t cpu_addr_o, // Byte address.
  output logic cpu_wr_o, // Write strobe.
  output logic cpu_rd_o, // Read strobe.
  output logic [7:0] cpu_wdata_o, // Write data.
  input wire logic [7:0] cpu_rdata_i // Read data.
);
  initial begin
    cpu_addr_o = 4'h0;
    cpu_wr_o = 1'b0;
    cpu_rd_o = 1'b0;
    cpu_wdata_o = 8'h00;
  end

  task automatic wr8(input frt_addr_t a, input logic [7:0] d);
    @(posedge clk_i) #1;
    cpu_addr_o = a;
    cpu_wdata_o = d;
    cpu_wr_o = 1'b1;
    @(posedge clk_i) #1;
    cpu_wr_o = 1'b0;
    cpu_wdata_o = ~d;
  endtask

  task automatic rd8(input frt_addr_t a, output logic [7:0] d);
    @(posedge clk_i) #1;
    cpu_addr_o = a;
    cpu_rd_o = 1'b1;
    @(posedge clk_i) #1;
    cpu_rd_o = 1'b0;
    d = cpu_rdata_i;
  endtask

  // Upper byte always goes first; the lower byte follows after one idle cycle.
  task automatic wr16(input frt_addr_t a, input frt_word_t w);
    wr8(a, w[15:8]);
    wr8(a + 4'h1, w[7:0]);
  endtask

  task automatic rd16(input frt_addr_t a, output frt_word_t w);
    rd8(a, w[15:8]);
    rd8(a + 4'h1, w[7:0]);
  endtask
endmodule

// File: tb/frt_timer_tb.sv
// Purpose: Self-checking bench for the capture/compare timer.
// Assumes: External count clock is selected where exact counts matter.
// Notes: Prescaled counts are checked within a window, as the prescaler phase is free.
`timescale 1ns/100ps
`include "frt_consts.svh"
module frt_timer_tb;
  import frt_pkg::*;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  frt_addr_t addr;
  logic wr, rd, ext;
  logic [7:0] wdata, rdata, d;
  logic [3:0] cap;
  logic pa, pa_oe, pb, pb_oe, irq_any;
  logic [6:0] irq;
  logic [2:0] irq_top;
  frt_word_t w;
  int errors = 0;
  int samples_checked = 0;

  always #4 clk = ~clk;

  frt_cpu_model i_cpu (.clk_i(clk), .cpu_addr_o(addr), .cpu_wr_o(wr), .cpu_rd_o(rd),
    .cpu_wdata_o(wdata), .cpu_rdata_i(rdata));

  frt_timer i_dut (.clk_i(clk), .rst_b_i(rst_b), .cpu_addr_i(addr), .cpu_wr_i(wr),
    .cpu_rd_i(rd), .cpu_wdata_i(wdata), .cpu_rdata_o(rdata), .capture_pin_i(cap),
    .ext_count_clock_pin_i(ext), .compare_pin_a_o(pa), .compare_pin_a_oe_o(pa_oe),
    .compare_pin_b_o(pb), .compare_pin_b_oe_o(pb_oe), .irq_o(irq), .irq_any_o(irq_any),
    .irq_top_o(irq_top));

  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    samples_checked++;
    if (s !== e) begin
      errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask

  // Pulses stay high four cycles, well above the minimum width.
  task automatic pulse(input int n);
    repeat (n) begin
      @(posedge clk) #1;
      ext = 1'b1;
      repeat (4) @(posedge clk);
      #1;
      ext = 1'b0;
      repeat (5) @(posedge clk);
      #1;
    end
  endtask

  task automatic settle();
    repeat (8) @(posedge clk);
    #1;
  endtask

  task automatic print_verdict();
    $display("checked=%0d errors=%0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  initial begin
    #200000;
    errors++;
    print_verdict();
  end

  initial begin
    ext = 1'b0;
    cap = 4'h2;
    repeat (3) @(posedge clk);
    #1;
    rst_b = 1'b1;
    i_cpu.rd8(`FRT_OFS_OUT_CTRL, d);
    chk(d, `FRT_RST_OUT_CTRL);
    chk({pa, pa_oe, pb, pb_oe}, 4'h0);
    i_cpu.rd16(`FRT_OFS_CMP_HI, w);
    chk(w, `FRT_RST_CMP);
    $display("reset test done");
    i_cpu.wr8(`FRT_OFS_CTRL, 8'h03);
    i_cpu.wr16(`FRT_OFS_CNT_HI, 16'h1234);
    i_cpu.rd8(`FRT_OFS_CNT_HI, d);
    chk(d, 8'h12);
    pulse(1);
    i_cpu.rd8(`FRT_OFS_CNT_LO, d);
    chk(d, 8'h34);
    i_cpu.rd16(`FRT_OFS_CNT_HI, w);
    chk(w, 16'h1235);
    i_cpu.wr16(`FRT_OFS_CMP_HI, 16'hABCD);
    i_cpu.rd8(`FRT_OFS_CMP_LO, d);
    chk(d, 8'hCD);
    i_cpu.wr8(`FRT_OFS_OUT_CTRL, 8'h10);
    i_cpu.rd16(`FRT_OFS_CMP_HI, w);
    chk(w, 16'hFFFF);
    $display("byte latch test done");
    i_cpu.wr8(`FRT_OFS_OUT_CTRL, 8'h0A);
    i_cpu.wr16(`FRT_OFS_CMP_HI, 16'h0005);
    i_cpu.wr8(`FRT_OFS_FLAGS, 8'h01);
    i_cpu.wr16(`FRT_OFS_CNT_HI, 16'h0000);
    pulse(5);
    chk(pa, 1'b0);
    pulse(1);
    chk({pa, pa_oe, pb, pb_oe}, 4'hC);
    i_cpu.rd16(`FRT_OFS_CNT_HI, w);
    chk(w, 16'h0000);
    i_cpu.rd8(`FRT_OFS_FLAGS, d);
    chk(d, 8'h09);
    i_cpu.wr8(`FRT_OFS_FLAGS, 8'hFF);
    i_cpu.rd8(`FRT_OFS_FLAGS, d);
    chk(d, 8'h09);
    i_cpu.wr8(`FRT_OFS_FLAGS, 8'h01);
    i_cpu.rd8(`FRT_OFS_FLAGS, d);
    chk(d, 8'h01);
    i_cpu.wr8(`FRT_OFS_OUT_CTRL, 8'h08);
    settle();
    chk(pa, 1'b1);
    pulse(6);
    chk(pa, 1'b0);
    $display("compare test done");
    i_cpu.wr8(`FRT_OFS_FLAGS, 8'h00);
    i_cpu.wr16(`FRT_OFS_CNT_HI, 16'hFFFF);
    pulse(1);
    i_cpu.rd16(`FRT_OFS_CNT_HI, w);
    chk(w, 16'h0000);
    i_cpu.rd8(`FRT_OFS_FLAGS, d);
    chk(d[1], 1'b1);
    $display("wrap test done");
    i_cpu.wr8(`FRT_OFS_CTRL, 8'h83);
    i_cpu.wr16(`FRT_OFS_CNT_HI, 16'h0042);
    cap[0] = 1'b1;
    settle();
    cap[1] = 1'b0;
    settle();
    i_cpu.rd16(`FRT_OFS_CAP_A_HI, w);
    chk(w, 16'h0042);
    i_cpu.rd16(`FRT_OFS_CAP_B_HI, w);
    chk(w, 16'h0042);
    i_cpu.rd8(`FRT_OFS_FLAGS, d);
    chk(d[7:6], 2'h3);
    i_cpu.wr8(`FRT_OFS_IRQ_EN, 8'h80);
    settle();
    chk({irq, irq_any, irq_top}, {7'h40, 1'b1, 3'h0});
    $display("capture test done");
    i_cpu.wr8(`FRT_OFS_CTRL, 8'hAB);
    i_cpu.wr16(`FRT_OFS_CNT_HI, 16'h0050);
    cap[0] = 1'b0;
    settle();
    cap[0] = 1'b1;
    settle();
    i_cpu.rd16(`FRT_OFS_CAP_A_HI, w);
    chk(w, 16'h0050);
    i_cpu.rd16(`FRT_OFS_CAP_C_HI, w);
    chk(w, 16'h0042);
    cap[2] = 1'b1;
    settle();
    i_cpu.rd16(`FRT_OFS_CAP_C_HI, w);
    chk(w, 16'h0042);
    i_cpu.rd8(`FRT_OFS_FLAGS, d);
    chk(d[5], 1'b1);
    // The rising edge on A is timed to reach the strobe in the cycle of the high-byte read.
    cap[0] = 1'b0;
    i_cpu.wr16(`FRT_OFS_CNT_HI, 16'h0060);
    cap[0] = 1'b1;
    @(posedge clk);
    i_cpu.rd16(`FRT_OFS_CAP_A_HI, w);
    chk(w, 16'h0050);
    settle();
    i_cpu.rd16(`FRT_OFS_CAP_A_HI, w);
    chk(w, 16'h0060);
    i_cpu.rd16(`FRT_OFS_CAP_C_HI, w);
    chk(w, 16'h0050);
    $display("buffer test done");
    // Any tick from the source switch comes before the counter write and is overwritten, so only the prescaler phase widens the window.
    for (int i = 0; i < 3; i++) begin
      i_cpu.wr8(`FRT_OFS_CTRL, 8'(i));
      i_cpu.wr16(`FRT_OFS_CNT_HI, 16'h0000);
      repeat (32 << (2 * i)) @(posedge clk);
      i_cpu.rd16(`FRT_OFS_CNT_HI, w);
      chk(w >= 16'h000F && w <= 16'h0012, 1'b1);
    end
    $display("prescaler test done");
    print_verdict();
  end
endmodule
